// ---- hw/dafs_status_regs.sv ----
// Read-only alarm and fault status bank of a motor drive.
// Assumes the serial-bus decoder gives an index and a read strobe.
`timescale 1ns/10ps
`default_nettype none
module dafs_status_regs
  import dafs_pkg::*;
#(
  parameter int CURR_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Fault reset action
  input wire logic fault_reset,
  // Detector conditions
  input wire dafs_pkg::dafs_alarm3_s alarm3_cond,
  input wire dafs_pkg::dafs_alarm4_s alarm4_cond,
  input wire dafs_pkg::dafs_alarm5_s alarm5_cond,
  input wire logic [8:0] cpf1_cond,
  input wire logic [9:0] cpf2_cond,
  input wire logic [3:0] option_cond,
  // Output current sample and range select
  input wire logic [CURR_W-1:0] current_raw,
  input wire logic large_rating,
  // Register read port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [15:0] rd_index,
  input wire logic broadcast,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Stored words
  output dafs_pkg::dafs_words_s words
);
  import dafs_pkg::*;

  // Current word is 16 bits wide; wider samples would be cut
  if (CURR_W < 1 || CURR_W > 16) begin : g_curr_w_check
    $error("CURR_W must be 1 to 16");
  end

  logic [15:0] a3_c, a4_c, a5_c, c1_c, c2_c, of_c;
  logic [15:0] curr_q;
  logic [15:0] sel_d;

  always_comb begin
    a3_c = 16'h0000;
    a3_c[DAFS_A3_SPEED] = alarm3_cond.speed_error_alarm;
    a3_c[DAFS_A3_ENC] = alarm3_cond.encoder_loss_alarm;
    a3_c[DAFS_A3_KEYPAD] = alarm3_cond.keypad_link_alarm;
    a3_c[DAFS_A3_BUSERR] = alarm3_cond.reg_bus_error;
    a3_c[DAFS_A3_OPTCOM] = alarm3_cond.option_comm_error;
    a3_c[DAFS_A3_TXERR_LO] = alarm3_cond.serial_tx_error;
    a3_c[DAFS_A3_TXERR_HI] = alarm3_cond.serial_tx_error;
    a3_c[DAFS_A3_MOTOL] = alarm3_cond.motor_overload_alarm;
    a3_c[DAFS_A3_DRVOL] = alarm3_cond.drive_overload_alarm;
    a3_c[DAFS_A3_OPTEXT] = alarm3_cond.option_ext_fault_alarm;
    a3_c[DAFS_A3_M2RUN] = alarm3_cond.motor2_switch_run;
    a3_c[DAFS_A3_UT1] = alarm3_cond.undertorque_1_alarm;
    a3_c[DAFS_A3_UT2] = alarm3_cond.undertorque_2_alarm;
    a3_c[DAFS_A3_TEST] = alarm3_cond.test_mode_alarm;
  end

  always_comb begin
    a4_c = 16'h0000;
    a4_c[DAFS_A4_THERM] = alarm4_cond.thermistor_overheat_alarm;
    a4_c[DAFS_A4_FBLOW] = alarm4_cond.pid_feedback_low;
    a4_c[DAFS_A4_FBHIGH] = alarm4_cond.pid_feedback_high;
    a4_c[DAFS_A4_DISABLED] = alarm4_cond.drive_disabled_alarm;
  end

  always_comb begin
    a5_c = 16'h0000;
    a5_c[DAFS_A5_WDOG] = alarm5_cond.fieldbus_watchdog_alarm;
    a5_c[DAFS_A5_PERIOD] = alarm5_cond.fieldbus_period_alarm;
    a5_c[DAFS_A5_HICUR] = alarm5_cond.high_current_alarm;
    a5_c[DAFS_A5_FAN] = alarm5_cond.fan_maintenance_alarm;
    a5_c[DAFS_A5_RELAY] = alarm5_cond.relay_maintenance_alarm;
    a5_c[DAFS_A5_NVM] = alarm5_cond.option_nvm_alarm;
    a5_c[DAFS_A5_S1] = alarm5_cond.input_s1_fault_alarm;
    a5_c[DAFS_A5_S2] = alarm5_cond.input_s2_fault_alarm;
    a5_c[DAFS_A5_SAFE_A] = alarm5_cond.safe_off_fault_alarm;
    a5_c[DAFS_A5_SAFE_B] = alarm5_cond.safe_off_input_alarm;
    a5_c[DAFS_A5_WEAR1] = alarm5_cond.mech_wear_1_alarm;
    a5_c[DAFS_A5_WEAR2] = alarm5_cond.mech_wear_2_alarm;
  end

  // Fault1 cond bits: 0 adc,1 modulation,2 board,3 term link,4 nvm link,
  // 5 ram,6 flash,7 watchdog,8 control
  assign c1_c = {1'b0, cpf1_cond[8:5], 2'b00, cpf1_cond[4:2], 2'b00,
                 cpf1_cond[1:0], 2'b00};
  assign c2_c = {6'h00, cpf2_cond};
  // Option cond bits: 0 incompatible,1 connection,2 selftest,3 flash mode
  assign of_c = {11'h000, option_cond[3:2], 1'b0, option_cond[1:0]};

  dafs_sticky_word #(.MASK(DAFS_MASK_ALARM3)) u_a3 (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(a3_c), .word_q(words.alarm3));
  dafs_sticky_word #(.MASK(DAFS_MASK_ALARM4)) u_a4 (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(a4_c), .word_q(words.alarm4));
  dafs_sticky_word #(.MASK(DAFS_MASK_ALARM5)) u_a5 (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(a5_c), .word_q(words.alarm5));
  dafs_sticky_word #(.MASK(DAFS_MASK_CPF1)) u_c1 (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(c1_c), .word_q(words.cpf1));
  dafs_sticky_word #(.MASK(DAFS_MASK_CPF2)) u_c2 (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(c2_c), .word_q(words.cpf2));
  dafs_sticky_word #(.MASK(DAFS_MASK_OPTF)) u_of (
    .ref_clk(ref_clk), .srst(srst), .fault_reset(fault_reset),
    .cond(of_c), .word_q(words.optf));

  // Current word: scaling is chosen upstream by rating; stored as sampled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      curr_q <= DAFS_RESET_WORD;
    end else begin
      curr_q <= 16'(current_raw);
    end
  end

  always_comb begin
    case (rd_index)
      DAFS_IDX_ALARM3: sel_d = words.alarm3;
      DAFS_IDX_ALARM4: sel_d = words.alarm4;
      DAFS_IDX_ALARM5: sel_d = words.alarm5;
      DAFS_IDX_CPF1: sel_d = words.cpf1;
      DAFS_IDX_CPF2: sel_d = words.cpf2;
      DAFS_IDX_OPTF: sel_d = words.optf;
      DAFS_IDX_CURR: sel_d = curr_q;
      default: sel_d = 16'h0000;
    endcase
  end

  // Broadcast reads never answer; writes have no effect here
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= DAFS_RESET_WORD;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en && !broadcast;
      if (rd_en && !broadcast) begin
        rd_data <= sel_d;
      end
    end
  end

  a_read_latency: assert property (@(posedge ref_clk) disable iff (srst)
    (rd_en && !broadcast) |=> rd_valid)
    else $error("read not answered");
  a_write_silent: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_en && !rd_en) |=> !rd_valid)
    else $error("write answered");
  a_broadcast_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    broadcast |=> !rd_valid)
    else $error("broadcast answered");
  a_fault_reload: assert property (@(posedge ref_clk) disable iff (srst)
    fault_reset |=> (words.alarm3 == $past(a3_c)))
    else $error("fault reset did not reload alarm word");
  a_tx_both_bits: assert property (@(posedge ref_clk) disable iff (srst)
    words.alarm3[DAFS_A3_TXERR_LO] == words.alarm3[DAFS_A3_TXERR_HI])
    else $error("tx error bits differ");
  a_speed_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.speed_error_alarm |=> words.alarm3[DAFS_A3_SPEED])
    else $error("speed alarm missed");
  a_enc_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.encoder_loss_alarm |=> words.alarm3[DAFS_A3_ENC])
    else $error("encoder alarm missed");
  a_keypad_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.keypad_link_alarm |=> words.alarm3[DAFS_A3_KEYPAD])
    else $error("keypad alarm missed");
  a_buserr_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.reg_bus_error |=> words.alarm3[DAFS_A3_BUSERR])
    else $error("bus error alarm missed");
  a_optcom_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.option_comm_error |=> words.alarm3[DAFS_A3_OPTCOM])
    else $error("option comm alarm missed");
  a_tx_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.serial_tx_error |=> words.alarm3[DAFS_A3_TXERR_LO])
    else $error("tx error alarm missed");
  a_motol_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.motor_overload_alarm |=> words.alarm3[DAFS_A3_MOTOL])
    else $error("motor overload alarm missed");
  a_drvol_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.drive_overload_alarm |=> words.alarm3[DAFS_A3_DRVOL])
    else $error("drive overload alarm missed");
  a_optext_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.option_ext_fault_alarm |=> words.alarm3[DAFS_A3_OPTEXT])
    else $error("option external alarm missed");
  a_m2_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.motor2_switch_run |=> words.alarm3[DAFS_A3_M2RUN])
    else $error("motor2 alarm missed");
  a_ut1_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.undertorque_1_alarm |=> words.alarm3[DAFS_A3_UT1])
    else $error("undertorque 1 alarm missed");
  a_ut2_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.undertorque_2_alarm |=> words.alarm3[DAFS_A3_UT2])
    else $error("undertorque 2 alarm missed");
  a_test_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm3_cond.test_mode_alarm |=> words.alarm3[DAFS_A3_TEST])
    else $error("test mode alarm missed");
  a_therm_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm4_cond.thermistor_overheat_alarm |=> words.alarm4[DAFS_A4_THERM])
    else $error("thermistor alarm missed");
  a_fblow_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm4_cond.pid_feedback_low |=> words.alarm4[DAFS_A4_FBLOW])
    else $error("feedback low alarm missed");
  a_fbhigh_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm4_cond.pid_feedback_high |=> words.alarm4[DAFS_A4_FBHIGH])
    else $error("feedback high alarm missed");
  a_disabled_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm4_cond.drive_disabled_alarm |=> words.alarm4[DAFS_A4_DISABLED])
    else $error("drive disabled alarm missed");
  a_wdog_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.fieldbus_watchdog_alarm |=> words.alarm5[DAFS_A5_WDOG])
    else $error("watchdog alarm missed");
  a_period_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.fieldbus_period_alarm |=> words.alarm5[DAFS_A5_PERIOD])
    else $error("period alarm missed");
  a_hicur_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.high_current_alarm |=> words.alarm5[DAFS_A5_HICUR])
    else $error("high current alarm missed");
  a_fan_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.fan_maintenance_alarm |=> words.alarm5[DAFS_A5_FAN])
    else $error("fan alarm missed");
  a_relay_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.relay_maintenance_alarm |=> words.alarm5[DAFS_A5_RELAY])
    else $error("relay alarm missed");
  a_nvm_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.option_nvm_alarm |=> words.alarm5[DAFS_A5_NVM])
    else $error("option memory alarm missed");
  a_s1_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.input_s1_fault_alarm |=> words.alarm5[DAFS_A5_S1])
    else $error("input s1 alarm missed");
  a_s2_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.input_s2_fault_alarm |=> words.alarm5[DAFS_A5_S2])
    else $error("input s2 alarm missed");
  a_safe_a_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.safe_off_fault_alarm |=> words.alarm5[DAFS_A5_SAFE_A])
    else $error("safe off fault alarm missed");
  a_safe_b_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.safe_off_input_alarm |=> words.alarm5[DAFS_A5_SAFE_B])
    else $error("safe off input alarm missed");
  a_wear1_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.mech_wear_1_alarm |=> words.alarm5[DAFS_A5_WEAR1])
    else $error("wear 1 alarm missed");
  a_wear2_capture: assert property (@(posedge ref_clk) disable iff (srst)
    alarm5_cond.mech_wear_2_alarm |=> words.alarm5[DAFS_A5_WEAR2])
    else $error("wear 2 alarm missed");
  a_adc_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[0] |=> words.cpf1[2])
    else $error("conversion fault missed");
  a_mod_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[1] |=> words.cpf1[3])
    else $error("modulation fault missed");
  a_board_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[2] |=> words.cpf1[6])
    else $error("board mismatch fault missed");
  a_tlink_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[3] |=> words.cpf1[7])
    else $error("terminal link fault missed");
  a_nvmlink_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[4] |=> words.cpf1[8])
    else $error("memory link fault missed");
  a_ram_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[5] |=> words.cpf1[11])
    else $error("ram fault missed");
  a_flash_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[6] |=> words.cpf1[12])
    else $error("flash fault missed");
  a_cwdog_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[7] |=> words.cpf1[13])
    else $error("watchdog circuit fault missed");
  a_ctrl_capture: assert property (@(posedge ref_clk) disable iff (srst)
    cpf1_cond[8] |=> words.cpf1[14])
    else $error("control circuit fault missed");
  a_cpf2_capture: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |=> ((words.cpf2[8:0] & $past(cpf2_cond[8:0])) == $past(cpf2_cond[8:0])))
    else $error("control fault word 2 bit missed");
  a_unseated_cap: assert property (@(posedge ref_clk) disable iff (srst)
    cpf2_cond[9] |=> words.cpf2[9])
    else $error("unseated fault missed");
  a_incompat_capture: assert property (@(posedge ref_clk) disable iff (srst)
    option_cond[0] |=> words.optf[0])
    else $error("incompatible fault missed");
  a_connect_capture: assert property (@(posedge ref_clk) disable iff (srst)
    option_cond[1] |=> words.optf[1])
    else $error("connection fault missed");
  a_option_cap: assert property (@(posedge ref_clk) disable iff (srst)
    option_cond[2] |=> words.optf[3])
    else $error("selftest fault missed");
  a_flashmode_capture: assert property (@(posedge ref_clk) disable iff (srst)
    option_cond[3] |=> words.optf[4])
    else $error("flash mode fault missed");
endmodule // dafs_status_regs
`default_nettype wire

// ---- hw/dafs_sticky_word.sv ----
// One sticky 16-bit status word.
// Assumes conditions are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module dafs_sticky_word #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic fault_reset,
  // Conditions and stored word
  input wire logic [15:0] cond,
  output logic [15:0] word_q
);
  // Set wins over fault reset so no event is lost
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      word_q <= dafs_pkg::DAFS_RESET_WORD;
    end else if (fault_reset) begin
      word_q <= cond & MASK;
    end else begin
      word_q <= (word_q | cond) & MASK;
    end
  end

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 ((word_q & ~MASK) == 16'h0000)) else $error("reserved bit set");
  a_sticky_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (!fault_reset ##1 1'b1) |-> ((word_q & $past(word_q)) == $past(word_q)))
    else $error("status bit lost without fault reset");
endmodule // dafs_sticky_word
`default_nettype wire

// ---- shared/dafs_pkg.sv ----
// Package for the drive alarm and fault status register bank.
// Assumes a 16-bit register index port driven by the serial-bus decoder.
`default_nettype none
package dafs_pkg;
  // Register indices
  localparam logic [15:0] DAFS_IDX_ALARM3 = 16'h00C9;
  localparam logic [15:0] DAFS_IDX_ALARM4 = 16'h00CA;
  localparam logic [15:0] DAFS_IDX_ALARM5 = 16'h00CB;
  localparam logic [15:0] DAFS_IDX_CPF1 = 16'h00D0;
  localparam logic [15:0] DAFS_IDX_CPF2 = 16'h00D1;
  localparam logic [15:0] DAFS_IDX_OPTF = 16'h00D8;
  localparam logic [15:0] DAFS_IDX_CURR = 16'h00FB;
  // Reset value of every word
  localparam logic [15:0] DAFS_RESET_WORD = 16'h0000;
  // Implemented-bit masks; zeros are reserved
  localparam logic [15:0] DAFS_MASK_ALARM3 = 16'hF6FF;
  localparam logic [15:0] DAFS_MASK_ALARM4 = 16'h02C2;
  localparam logic [15:0] DAFS_MASK_ALARM5 = 16'h3FBD;
  localparam logic [15:0] DAFS_MASK_CPF1 = 16'h79CC;
  localparam logic [15:0] DAFS_MASK_CPF2 = 16'h03FF;
  localparam logic [15:0] DAFS_MASK_OPTF = 16'h001B;
  // Alarm word 3 positions
  localparam int DAFS_A3_SPEED = 0;
  localparam int DAFS_A3_ENC = 1;
  localparam int DAFS_A3_KEYPAD = 2;
  localparam int DAFS_A3_BUSERR = 3;
  localparam int DAFS_A3_OPTCOM = 4;
  localparam int DAFS_A3_TXERR_LO = 5;
  localparam int DAFS_A3_MOTOL = 6;
  localparam int DAFS_A3_DRVOL = 7;
  localparam int DAFS_A3_OPTEXT = 9;
  localparam int DAFS_A3_M2RUN = 10;
  localparam int DAFS_A3_TXERR_HI = 12;
  localparam int DAFS_A3_UT1 = 13;
  localparam int DAFS_A3_UT2 = 14;
  localparam int DAFS_A3_TEST = 15;
  // Alarm word 4 positions
  localparam int DAFS_A4_THERM = 1;
  localparam int DAFS_A4_FBLOW = 6;
  localparam int DAFS_A4_FBHIGH = 7;
  localparam int DAFS_A4_DISABLED = 9;
  // Alarm word 5 positions
  localparam int DAFS_A5_WDOG = 0;
  localparam int DAFS_A5_PERIOD = 2;
  localparam int DAFS_A5_HICUR = 3;
  localparam int DAFS_A5_FAN = 4;
  localparam int DAFS_A5_RELAY = 5;
  localparam int DAFS_A5_NVM = 7;
  localparam int DAFS_A5_S1 = 8;
  localparam int DAFS_A5_S2 = 9;
  localparam int DAFS_A5_SAFE_A = 10;
  localparam int DAFS_A5_SAFE_B = 11;
  localparam int DAFS_A5_WEAR1 = 12;
  localparam int DAFS_A5_WEAR2 = 13;

  // Raw detector conditions of the three alarm words, then the stored words
  typedef struct packed {
    logic test_mode_alarm;
    logic undertorque_2_alarm;
    logic undertorque_1_alarm;
    logic motor2_switch_run;
    logic option_ext_fault_alarm;
    logic drive_overload_alarm;
    logic motor_overload_alarm;
    logic serial_tx_error;
    logic option_comm_error;
    logic reg_bus_error;
    logic keypad_link_alarm;
    logic encoder_loss_alarm;
    logic speed_error_alarm;
  } dafs_alarm3_s;

  typedef struct packed {
    logic drive_disabled_alarm;
    logic pid_feedback_high;
    logic pid_feedback_low;
    logic thermistor_overheat_alarm;
  } dafs_alarm4_s;

  typedef struct packed {
    logic mech_wear_2_alarm;
    logic mech_wear_1_alarm;
    logic safe_off_input_alarm;
    logic safe_off_fault_alarm;
    logic input_s2_fault_alarm;
    logic input_s1_fault_alarm;
    logic option_nvm_alarm;
    logic relay_maintenance_alarm;
    logic fan_maintenance_alarm;
    logic high_current_alarm;
    logic fieldbus_period_alarm;
    logic fieldbus_watchdog_alarm;
  } dafs_alarm5_s;

  typedef struct packed {
    logic [15:0] alarm3;
    logic [15:0] alarm4;
    logic [15:0] alarm5;
    logic [15:0] cpf1;
    logic [15:0] cpf2;
    logic [15:0] optf;
  } dafs_words_s;
endpackage
`default_nettype wire

// ---- tb/dafs_bus_master.sv ----
// Serial-bus master model that issues register reads and writes.
// Assumes the bank answers a taken read with one rd_valid strobe.
`timescale 1ns/10ps
`default_nettype none
module dafs_bus_master (
  // Clock
  input wire logic ref_clk,
  // Request side
  output logic rd_en,
  output logic wr_en,
  output logic [15:0] rd_index,
  output logic broadcast,
  // Answer side
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    rd_index = 16'h0000;
    broadcast = 1'b0;
  end

  // One access; wr high makes it a write, bc high a broadcast
  task automatic acc(input logic [15:0] idx, input logic bc, input logic wr,
                     output logic [15:0] d, output logic got);
    @(negedge ref_clk);
    rd_index = idx;
    broadcast = bc;
    rd_en = ~wr;
    wr_en = wr;
    @(posedge ref_clk);
    @(negedge ref_clk);
    rd_en = 1'b0;
    wr_en = 1'b0;
    broadcast = 1'b0;
    // Released index toggles so a stale index never looks valid
    rd_index = ~idx;
    got = 1'b0;
    d = 16'h0000;
    // Broadcasts get no answer, so the wait is bounded
    for (int i = 0; i < 3; i++) begin
      if (rd_valid === 1'b1 && got === 1'b0) begin
        got = 1'b1;
        d = rd_data;
      end
      @(negedge ref_clk);
    end
  endtask
endmodule // dafs_bus_master
`default_nettype wire

// ---- tb/drive_alarm_fault_status_regs_tb_top.sv ----
// Testbench for the alarm and fault status bank with a behavioural model.
// Assumes the bus master model drives all register requests.
`timescale 1ns/10ps
`default_nettype none
module drive_alarm_fault_status_regs_tb_top;
  import dafs_pkg::*;
  // Bit position of each detector input, -1 unused
  localparam int TAB[6][13] = '{
    '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 13, 14, 15},
    '{1, 6, 7, 9, -1, -1, -1, -1, -1, -1, -1, -1, -1},
    '{0, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13, -1},
    '{2, 3, 6, 7, 8, 11, 12, 13, 14, -1, -1, -1, -1},
    '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, -1, -1, -1},
    '{0, 1, 3, 4, -1, -1, -1, -1, -1, -1, -1, -1, -1}};
  localparam logic [15:0] IDX[7] = '{DAFS_IDX_ALARM3, DAFS_IDX_ALARM4, DAFS_IDX_ALARM5,
    DAFS_IDX_CPF1, DAFS_IDX_CPF2, DAFS_IDX_OPTF, DAFS_IDX_CURR};
  logic ref_clk, srst, fault_reset, large_rating, rd_en, wr_en, broadcast, rd_valid;
  logic [15:0] rd_index, rd_data, current_raw;
  logic [12:0] cnd[6];
  logic [15:0] xp[6];
  dafs_words_s words;
  int n_mismatch = 0;
  int samples_checked = 0;

  dafs_status_regs u_dafs_status_regs (.ref_clk(ref_clk), .srst(srst),
    .fault_reset(fault_reset), .alarm3_cond(cnd[0]), .alarm4_cond(cnd[1][3:0]),
    .alarm5_cond(cnd[2][11:0]), .cpf1_cond(cnd[3][8:0]), .cpf2_cond(cnd[4][9:0]),
    .option_cond(cnd[5][3:0]), .current_raw(current_raw), .large_rating(large_rating),
    .rd_en(rd_en), .wr_en(wr_en), .rd_index(rd_index), .broadcast(broadcast),
    .rd_data(rd_data), .rd_valid(rd_valid), .words(words));
  dafs_bus_master u_dafs_bus_master (.ref_clk(ref_clk), .rd_en(rd_en), .wr_en(wr_en),
    .rd_index(rd_index), .broadcast(broadcast), .rd_data(rd_data), .rd_valid(rd_valid));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [15:0] spread(int w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 13; i++) begin
      if (TAB[w][i] >= 0 && cnd[w][i]) r[TAB[w][i]] = 1'b1;
    end
    if (w == 0 && cnd[0][5]) r[12] = 1'b1;
    return r;
  endfunction

  // Sticky model: fault reset reloads with present conditions
  always @(posedge ref_clk) begin
    for (int w = 0; w < 6; w++) begin
      if (srst) xp[w] <= 16'h0000;
      else if (fault_reset) xp[w] <= spread(w);
      else xp[w] <= xp[w] | spread(w);
    end
  end

  task automatic check(input string nm, input logic [95:0] e, input logic [95:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_all();
    logic [15:0] d;
    logic got;
    check("words", {xp[0], xp[1], xp[2], xp[3], xp[4], xp[5]}, words);
    u_dafs_bus_master.acc(IDX[$urandom % 6], 1'b0, 1'b1, d, got);
    check("write_ack", 96'h0, {95'h0, got});
    for (int k = 0; k < 7; k++) begin
      u_dafs_bus_master.acc(IDX[k], 1'b0, 1'b0, d, got);
      check("read_ack", 96'h1, {95'h0, got});
      check("read_data", (k == 6) ? current_raw : xp[k], d);
    end
    u_dafs_bus_master.acc(16'h00CC, 1'b0, 1'b0, d, got);
    check("unmapped", 96'h0, d);
    u_dafs_bus_master.acc(DAFS_IDX_ALARM3, 1'b1, 1'b0, d, got);
    check("bcast_ack", 96'h0, {95'h0, got});
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    fault_reset = 1'b0;
    large_rating = 1'b0;
    current_raw = 16'h0000;
    for (int w = 0; w < 6; w++) cnd[w] = 13'h0000;
    void'($urandom(94373));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    for (int it = 0; it < 40; it++) begin
      // Sparse conditions so fault reset has bits to clear
      for (int w = 0; w < 6; w++) cnd[w] = 13'($urandom & $urandom & $urandom);
      fault_reset = ($urandom % 4) == 0;
      large_rating = 1'($urandom);
      current_raw = 16'($urandom);
      repeat (2) @(negedge ref_clk);
      for (int w = 0; w < 6; w++) cnd[w] = 13'h0000;
      fault_reset = 1'b0;
      @(negedge ref_clk);
      if (it == 30) begin
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
      end
      check_all();
    end
    complete_run();
  end

  // Hang guard, far beyond the roughly 2000 cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule // drive_alarm_fault_status_regs_tb_top
`default_nettype wire
